// ### hdm_homing.sv
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "hdm_regs.svh"
module hdm_homing (
  input wire clk,
  input wire rstn,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output logic [31:0] rdata,
  input wire dog_in,
  input wire hdm_pkg::hdm_amp_t amp,
  input wire [31:0] enc_pos,
  input wire before_dog,
  input wire power_restored,
  input wire prog_start,
  input wire prog_is_homing,
  output logic prog_accept,
  output hdm_pkg::hdm_speed_t speed_cmd,
  output logic creep_torque_en,
  output logic homing_complete,
  output logic homing_request_flag,
  output logic zero_pass_flag,
  output logic irq
);

  // ****************************************
  // state
  // ****************************************
  hdm_pkg::hdm_state_t s;
  hdm_pkg::hdm_state_t next_s;
  hdm_pkg::hdm_req_t req;
  logic [3:0] ev;
  logic start_cmd;
  logic dog_fall;
  logic zp_now;

  hdm_method_req u_req (
    .method(s.method),
    .req(req)
  );

  function automatic hdm_pkg::hdm_speed_t speed_of(input hdm_pkg::hdm_st_t st);
    case (st)
      hdm_pkg::HDM_FAST, hdm_pkg::HDM_DECEL: speed_of = hdm_pkg::HDM_SPD_HOME;
      hdm_pkg::HDM_CREEP, hdm_pkg::HDM_SEEK: speed_of = hdm_pkg::HDM_SPD_CREEP;
      hdm_pkg::HDM_SEEK_STOP, hdm_pkg::HDM_ABORT: speed_of = hdm_pkg::HDM_SPD_DSTOP;
      default: speed_of = hdm_pkg::HDM_SPD_NONE;
    endcase
  endfunction

  assign start_cmd = wr && (addr == `HDM_ADDR_CTRL) && wdata[`HDM_CTRL_START];
  assign dog_fall = !dog_in && s.dog_q;
  // a zero point in the very cycle of the dog-off still counts
  assign zp_now = s.zpass || amp.zero_point || s.zwaive;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.rdata = 32'h0000_0000;
    next_s.prog_ok = 1'b0;
    next_s.dog_q = dog_in;
    ev = 4'h0;

    if (amp.zero_point || s.zwaive) begin
      next_s.zpass = 1'b1;
    end
    if (before_dog) begin
      next_s.beyond = 1'b0;
    end
    // set wins over the clear from the position compare
    if (dog_fall || (power_restored && s.complete)) begin
      next_s.beyond = 1'b1;
    end

    if (wr) begin
      case (addr)
        `HDM_ADDR_CTRL: begin
          next_s.retry = wdata[`HDM_CTRL_RETRY];
          next_s.zwaive = wdata[`HDM_CTRL_ZWAIVE];
          next_s.blk = wdata[`HDM_CTRL_BLOCK];
          // method is frozen while a sequence runs
          if (s.st == hdm_pkg::HDM_IDLE) begin
            next_s.method = hdm_pkg::hdm_method_t'(wdata[`HDM_CTRL_METHOD]);
          end
        end
        `HDM_ADDR_ERR: begin
          next_s.err_code = 16'h0000;
          next_s.err_major = 1'b0;
        end
        `HDM_ADDR_IRQ_MASK: next_s.irq_mask = wdata[3:0];
        default: begin
        end
      endcase
    end

    case (s.st)
      hdm_pkg::HDM_IDLE: begin
        // only the first dog variant is served; other methods ignore start
        if (start_cmd && s.method == hdm_pkg::HDM_DOG1) begin
          if (!s.retry && (s.complete || s.beyond)) begin
            next_s.err_code = `HDM_ERR_COMPLETE_ON;
            next_s.err_major = 1'b0;
            ev[`HDM_IRQ_MINOR] = 1'b1;
          end else if (dog_in) begin
            next_s.err_code = `HDM_ERR_DOG_ON;
            next_s.err_major = 1'b1;
            ev[`HDM_IRQ_MAJOR] = 1'b1;
          end else begin
            next_s.zpass = s.zwaive;
            next_s.complete = 1'b0;
            next_s.request = 1'b1;
            next_s.st = hdm_pkg::HDM_FAST;
          end
        end
      end
      hdm_pkg::HDM_FAST: begin
        if (dog_in) begin
          next_s.st = hdm_pkg::HDM_DECEL;
        end
      end
      hdm_pkg::HDM_DECEL, hdm_pkg::HDM_CREEP: begin
        if (!dog_in) begin
          if (!zp_now) begin
            next_s.st = hdm_pkg::HDM_ABORT;
            next_s.err_code = `HDM_ERR_ZCT;
            next_s.err_major = 1'b0;
            ev[`HDM_IRQ_MINOR] = 1'b1;
          end else if (s.st == hdm_pkg::HDM_DECEL) begin
            next_s.st = hdm_pkg::HDM_SEEK_STOP;
          end else begin
            next_s.st = hdm_pkg::HDM_SEEK;
          end
        end else if (s.st == hdm_pkg::HDM_DECEL && amp.at_creep) begin
          next_s.st = hdm_pkg::HDM_CREEP;
        end
      end
      hdm_pkg::HDM_SEEK, hdm_pkg::HDM_SEEK_STOP: begin
        if (amp.zero_point) begin
          next_s.home_pos = enc_pos;
          next_s.st = hdm_pkg::HDM_SETTLE;
        end
      end
      hdm_pkg::HDM_SETTLE: begin
        if (amp.axis_in_position_flag) begin
          next_s.complete = 1'b1;
          next_s.request = 1'b0;
          next_s.st = hdm_pkg::HDM_IDLE;
          ev[`HDM_IRQ_DONE] = 1'b1;
        end
      end
      hdm_pkg::HDM_ABORT: begin
        if (amp.stopped) begin
          next_s.st = hdm_pkg::HDM_IDLE;
        end
      end
      default: next_s.st = hdm_pkg::HDM_IDLE;
    endcase
    next_s.speed = speed_of(next_s.st);

    if (prog_start) begin
      if (s.blk && s.request && !prog_is_homing) begin
        next_s.err_code = `HDM_ERR_REQ_ON;
        next_s.err_major = 1'b0;
        ev[`HDM_IRQ_REFUSE] = 1'b1;
      end else begin
        next_s.prog_ok = 1'b1;
      end
    end

    // write one clears, but a new event in the same cycle survives
    next_s.irq_stat = s.irq_stat;
    if (wr && addr == `HDM_ADDR_IRQ_STAT) begin
      next_s.irq_stat = s.irq_stat & ~wdata[3:0];
    end
    next_s.irq_stat = next_s.irq_stat | ev;

    if (rd) begin
      case (addr)
        `HDM_ADDR_CTRL: next_s.rdata = {24'h00_0000, s.method, s.blk, s.zwaive, s.retry, 1'b0};
        `HDM_ADDR_STATUS: next_s.rdata = {20'h0_0000, req, 3'h0, s.beyond, s.zpass, s.request,
                                          s.complete, s.st != hdm_pkg::HDM_IDLE};
        `HDM_ADDR_ERR: next_s.rdata = {15'h0000, s.err_major, s.err_code};
        `HDM_ADDR_HOME: next_s.rdata = s.home_pos;
        `HDM_ADDR_IRQ_STAT: next_s.rdata = {28'h000_0000, s.irq_stat};
        `HDM_ADDR_IRQ_MASK: next_s.rdata = {28'h000_0000, s.irq_mask};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.request <= `HDM_REQ_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign prog_accept = s.prog_ok;
  assign speed_cmd = s.speed;
  assign creep_torque_en = req.creep_torque && (s.speed == hdm_pkg::HDM_SPD_CREEP);
  assign homing_complete = s.complete;
  assign homing_request_flag = s.request;
  assign zero_pass_flag = s.zpass;
  assign irq = |(s.irq_stat & s.irq_mask);

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_done_after_inpos: assert property ($rose(homing_complete) |-> $past(amp.axis_in_position_flag)
    && $past(s.st) == hdm_pkg::HDM_SETTLE) else $error("complete without in-position");
  a_done_clears_request: assert property ($rose(homing_complete) |-> !homing_request_flag
    && $past(s.st, 2) != hdm_pkg::HDM_IDLE) else $error("request not cleared at completion");
  a_zct_abort: assert property (s.st == hdm_pkg::HDM_CREEP && !dog_in && !zp_now
    |=> s.st == hdm_pkg::HDM_ABORT && s.err_code == `HDM_ERR_ZCT && !homing_complete)
    else $error("missing zero pass not flagged");
  a_waive_proceeds: assert property (s.st == hdm_pkg::HDM_CREEP && !dog_in && s.zwaive
    |=> s.st == hdm_pkg::HDM_SEEK) else $error("waiver ignored");
  a_dog_on_refused: assert property (s.st == hdm_pkg::HDM_IDLE && start_cmd && dog_in
    && s.method == hdm_pkg::HDM_DOG1 && (s.retry || (!s.complete && !s.beyond))
    |=> s.st == hdm_pkg::HDM_IDLE && s.err_major && s.err_code == `HDM_ERR_DOG_ON)
    else $error("start with dog on not refused");
  a_complete_refused: assert property (s.st == hdm_pkg::HDM_IDLE && start_cmd && s.complete
    && !s.retry && s.method == hdm_pkg::HDM_DOG1
    |=> s.st == hdm_pkg::HDM_IDLE && s.err_code == `HDM_ERR_COMPLETE_ON)
    else $error("restart after completion not refused");
  a_beyond_refused: assert property (s.st == hdm_pkg::HDM_IDLE && start_cmd && s.beyond && !s.retry
    |=> s.st == hdm_pkg::HDM_IDLE) else $error("start beyond dog accepted");
  a_zpass_cleared: assert property (s.st == hdm_pkg::HDM_IDLE && $changed(s.st) == 1'b0
    ##1 s.st == hdm_pkg::HDM_FAST |-> zero_pass_flag == $past(s.zwaive))
    else $error("zero pass not cleared at start");
  a_home_latched: assert property (s.st == hdm_pkg::HDM_SEEK && amp.zero_point
    |=> s.home_pos == $past(enc_pos) && s.st == hdm_pkg::HDM_SETTLE)
    else $error("home not latched at zero point");
  a_early_dog_off: assert property (s.st == hdm_pkg::HDM_DECEL && !dog_in && zp_now
    |=> speed_cmd == hdm_pkg::HDM_SPD_DSTOP ##1 speed_cmd != hdm_pkg::HDM_SPD_CREEP)
    else $error("early dog off not stopped");
  a_prog_refused: assert property (prog_start && s.blk && s.request && !prog_is_homing
    |=> !prog_accept && s.err_code == `HDM_ERR_REQ_ON) else $error("program start not refused");
  a_no_creep_torque: assert property (s.method == hdm_pkg::HDM_DOG1 |-> !creep_torque_en)
    else $error("creep torque used by dog method");

  c_homing_done: cover property ($rose(homing_complete));
  c_zct_abort: cover property (s.st == hdm_pkg::HDM_ABORT && s.err_code == `HDM_ERR_ZCT);
  c_dog_on_start: cover property (s.err_code == `HDM_ERR_DOG_ON);
  c_early_stop: cover property (s.st == hdm_pkg::HDM_SEEK_STOP ##[1:50] s.st == hdm_pkg::HDM_SETTLE);

endmodule // hdm_homing

// ### hdm_regs.svh
`ifndef HDM_REGS_SVH
`define HDM_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define HDM_ADDR_CTRL 8'h00
`define HDM_ADDR_STATUS 8'h04
`define HDM_ADDR_ERR 8'h08
`define HDM_ADDR_HOME 8'h0C
`define HDM_ADDR_IRQ_STAT 8'h10
`define HDM_ADDR_IRQ_MASK 8'h14

// ****************************************
// control fields
// ****************************************
`define HDM_CTRL_START 0
`define HDM_CTRL_RETRY 1
`define HDM_CTRL_ZWAIVE 2
`define HDM_CTRL_BLOCK 3
`define HDM_CTRL_METHOD 7:4

// ****************************************
// interrupt bits
// ****************************************
`define HDM_IRQ_DONE 0
`define HDM_IRQ_MINOR 1
`define HDM_IRQ_MAJOR 2
`define HDM_IRQ_REFUSE 3

// ****************************************
// error codes and reset values
// ****************************************
`define HDM_ERR_COMPLETE_ON 16'h0073
`define HDM_ERR_ZCT 16'h0078
`define HDM_ERR_REQ_ON 16'h0079
`define HDM_ERR_DOG_ON 16'h03EB
`define HDM_REQ_RST 1'b1

`endif

// ### hdm_pkg.sv
package hdm_pkg;

  typedef enum logic [2:0] {
    HDM_IDLE, HDM_FAST, HDM_DECEL, HDM_CREEP, HDM_SEEK, HDM_SEEK_STOP, HDM_SETTLE, HDM_ABORT
  } hdm_st_t;

  typedef enum logic [1:0] {HDM_SPD_NONE, HDM_SPD_HOME, HDM_SPD_CREEP, HDM_SPD_DSTOP} hdm_speed_t;

  typedef enum logic [3:0] {
    HDM_DOG1, HDM_DOG2, HDM_CNT1, HDM_CNT2, HDM_CNT3, HDM_DSET1, HDM_DSET2,
    HDM_CRADLE, HDM_STOP1, HDM_STOP2, HDM_LIMIT
  } hdm_method_t;

  typedef struct packed {
    logic zero_point;
    logic axis_in_position_flag;
    logic at_creep;
    logic stopped;
  } hdm_amp_t;

  typedef struct packed {
    logic shift_speed;
    logic creep_torque;
    logic incomplete_op;
    logic accel_group;
  } hdm_req_t;

  typedef struct packed {
    hdm_st_t st;
    hdm_speed_t speed;
    logic retry;
    logic zwaive;
    logic blk;
    hdm_method_t method;
    logic complete;
    logic request;
    logic zpass;
    logic beyond;
    logic dog_q;
    logic prog_ok;
    logic err_major;
    logic [15:0] err_code;
    logic [31:0] home_pos;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [31:0] rdata;
  } hdm_state_t;

endpackage

// ### hdm_method_req.sv
`timescale 1ns/1ps
module hdm_method_req (
  input wire hdm_pkg::hdm_method_t method,
  output hdm_pkg::hdm_req_t req
);

  logic dset;

  assign dset = (method == hdm_pkg::HDM_DSET1) || (method == hdm_pkg::HDM_DSET2);
  assign req.shift_speed = !dset;
  assign req.creep_torque = (method == hdm_pkg::HDM_STOP1) || (method == hdm_pkg::HDM_STOP2);
  assign req.incomplete_op = 1'b1;
  assign req.accel_group = !dset;

endmodule // hdm_method_req

// ### hdm_amp_model.sv
`timescale 1ns/1ps
// ****************************************
// amplifier, encoder and dog partner
// ****************************************
module hdm_amp_model (
  input wire clk,
  input wire rstn,
  input wire hdm_pkg::hdm_speed_t speed_cmd,
  input wire dog_in,
  input wire zp,
  output hdm_pkg::hdm_amp_t amp,
  output logic [31:0] enc_pos
);
  logic [3:0] dog_cnt;
  logic [3:0] stop_cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dog_cnt <= 4'h0;
      stop_cnt <= 4'h0;
      enc_pos <= 32'h0000_0100;
    end else begin
      // creep is reached only after four cycles on the dog, so a short dog misses it
      dog_cnt <= (dog_in && speed_cmd != hdm_pkg::HDM_SPD_NONE) ? dog_cnt + 4'(dog_cnt != 4'hF) : 4'h0;
      stop_cnt <= (speed_cmd == hdm_pkg::HDM_SPD_NONE || speed_cmd == hdm_pkg::HDM_SPD_DSTOP) ?
                  stop_cnt + 4'(stop_cnt != 4'hF) : 4'h0;
      enc_pos <= amp.stopped ? enc_pos : enc_pos + 32'h0000_0001;
    end
  end
  always_comb begin
    amp.zero_point = zp;
    amp.at_creep = dog_cnt >= 4'h4;
    amp.stopped = stop_cnt >= 4'h3;
    // in-position settles well after standstill, never at once
    amp.axis_in_position_flag = stop_cnt >= 4'h6 && speed_cmd == hdm_pkg::HDM_SPD_NONE;
  end
endmodule // hdm_amp_model

// ### hdm_homing_tb_top.sv
`timescale 1ns/1ps
module hdm_homing_tb_top;
  logic clk, rstn, wr, rd, dog_in, zp, prog_start, prog_is_homing, before_dog;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, enc_pos, v, e;
  hdm_pkg::hdm_amp_t amp;
  hdm_pkg::hdm_speed_t speed_cmd;
  logic prog_accept, creep_torque_en, homing_complete, homing_request_flag, zero_pass_flag, irq;
  int mismatches, checks;
  hdm_homing u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .dog_in(dog_in), .amp(amp), .enc_pos(enc_pos), .before_dog(before_dog), .power_restored(1'b0),
    .prog_start(prog_start), .prog_is_homing(prog_is_homing), .prog_accept(prog_accept),
    .speed_cmd(speed_cmd), .creep_torque_en(creep_torque_en), .homing_complete(homing_complete),
    .homing_request_flag(homing_request_flag), .zero_pass_flag(zero_pass_flag), .irq(irq));
  hdm_amp_model u_amp (.clk(clk), .rstn(rstn), .speed_cmd(speed_cmd), .dog_in(dog_in), .zp(zp),
    .amp(amp), .enc_pos(enc_pos));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    @(negedge clk); v = rdata;
  endtask
  task automatic wait_spd(input hdm_pkg::hdm_speed_t s);
    bit found;
    found = 0;
    for (int i = 0; i < 80 && !found; i++) begin
      @(negedge clk);
      found = (speed_cmd === s);
    end
    if (!found) begin
      chk(32'(speed_cmd), 32'(s));
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic pulse_zp();
    @(posedge clk); zp <= 1'b1;
    @(negedge clk); e = enc_pos;
    @(posedge clk); zp <= 1'b0;
  endtask
  task automatic start(input logic retry, input logic zw, input logic zp_early, input int dog_cyc);
    wr_reg(8'h00, {29'h0, zw, retry, 1'b1});
    wait_spd(hdm_pkg::HDM_SPD_HOME);
    if (zp_early) pulse_zp();
    @(posedge clk); dog_in <= 1'b1;
    repeat (dog_cyc) @(posedge clk);
    dog_in <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic finish_home();
    wait_spd(hdm_pkg::HDM_SPD_NONE);
    repeat (12) @(posedge clk);
    chk(homing_complete, 1'b1);
    rd_reg(8'h0C); chk(v, e);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_prog();
    chk(homing_request_flag, 1'b1);
    wr_reg(8'h00, 32'h0000_0008);
    for (int h = 0; h < 2; h++) begin
      @(posedge clk); prog_start <= 1'b1; prog_is_homing <= h[0];
      @(posedge clk); prog_start <= 1'b0;
      @(negedge clk); chk(prog_accept, h[0]);
      rd_reg(8'h08); chk(v[15:0], 16'h0079);
    end
    wr_reg(8'h08, 32'h0000_0000);
  endtask
  task automatic s_normal();
    bit done;
    done = 0;
    start(1'b0, 1'b0, 1'b1, 8);
    chk(zero_pass_flag, 1'b1);
    chk(32'(speed_cmd), 32'(hdm_pkg::HDM_SPD_CREEP));
    pulse_zp();
    wait_spd(hdm_pkg::HDM_SPD_NONE);
    chk(homing_complete, 1'b0);
    for (int i = 0; i < 40 && !done; i++) begin
      @(negedge clk);
      done = (homing_complete === 1'b1);
    end
    if (!done) begin
      chk(homing_complete, 1'b1);
      report_and_stop();
    end
    chk(amp.axis_in_position_flag, 1'b1);
    chk(homing_request_flag, 1'b0);
    rd_reg(8'h0C); chk(v, e);
    chk(irq, 1'b0);
    wr_reg(8'h14, 32'h0000_0001);
    @(negedge clk); chk(irq, 1'b1);
    wr_reg(8'h10, 32'h0000_000F);
    @(negedge clk); chk(irq, 1'b0);
  endtask
  task automatic s_refuse();
    wr_reg(8'h00, 32'h0000_0001);
    rd_reg(8'h08); chk(v, 32'h0000_0073);
    chk(32'(speed_cmd), 32'(hdm_pkg::HDM_SPD_NONE));
    wr_reg(8'h08, 32'h0000_0000);
    // retry must already stand when the start is taken
    wr_reg(8'h00, 32'h0000_0002);
    @(posedge clk); dog_in <= 1'b1;
    wr_reg(8'h00, 32'h0000_0003);
    rd_reg(8'h08); chk(v, 32'h0001_03EB);
    chk(32'(speed_cmd), 32'(hdm_pkg::HDM_SPD_NONE));
    @(posedge clk); dog_in <= 1'b0;
    repeat (2) @(posedge clk);
    rd_reg(8'h04); chk(v[4], 1'b1);
    @(posedge clk); before_dog <= 1'b1;
    @(posedge clk); before_dog <= 1'b0;
    rd_reg(8'h04); chk(v[4], 1'b0);
    wr_reg(8'h08, 32'h0000_0000);
  endtask
  task automatic s_no_zero();
    start(1'b1, 1'b0, 1'b0, 8);
    chk(zero_pass_flag, 1'b0);
    wait_spd(hdm_pkg::HDM_SPD_DSTOP);
    rd_reg(8'h08); chk(v, 32'h0000_0078);
    wait_spd(hdm_pkg::HDM_SPD_NONE);
    wr_reg(8'h08, 32'h0000_0000);
    start(1'b1, 1'b1, 1'b0, 8);
    chk(32'(speed_cmd), 32'(hdm_pkg::HDM_SPD_CREEP));
    pulse_zp();
    finish_home();
    rd_reg(8'h08); chk(v, 32'h0000_0000);
  endtask
  task automatic s_short_dog();
    start(1'b1, 1'b0, 1'b1, 2);
    chk(32'(speed_cmd), 32'(hdm_pkg::HDM_SPD_DSTOP));
    pulse_zp();
    finish_home();
  endtask
  task automatic s_methods();
    logic [3:0] m [3] = '{4'h0, 4'h8, 4'h5};
    logic [3:0] x [3] = '{4'hB, 4'hF, 4'h2};
    for (int i = 0; i < 3; i++) begin
      wr_reg(8'h00, {24'h0, m[i], 4'h2});
      rd_reg(8'h04); chk(v[11:8], x[i]);
    end
    chk(creep_torque_en, 1'b0);
    wr_reg(8'h00, 32'h0000_0002);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rstn, wr, rd, dog_in, zp, prog_start, prog_is_homing, before_dog} = 8'h00;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    mismatches = 0;
    checks = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    s_prog();
    s_normal();
    s_refuse();
    s_no_zero();
    s_short_dog();
    s_methods();
    report_and_stop();
  end
endmodule // hdm_homing_tb_top
